// ==== rtl/interrupt_vector_dma_request_map.sv ====
// Maps peripheral events to vectors, fetch addresses and DMA requests
//
// Behaviour
// - Serial ch3 transmit done uses vector 27, offset 0x390, resource 11.
// - Serial ch4 receive and status share vector 28, offset 0x38c, resource 12.
// - CAN1 and RAM diagnosis events share vector 35, offset 0x370, no DMA.
// - Timer 0 and serial ch7 transmit share vector 39, 0x360, resource 23.
// - Pulse channels group and timer 1 share vector 40, 0x35c, resource 24.
// - Compare units 6,7,10,11 use vector 58, offset 0x314, resource 42.
// - Vectors 66 to 255 are software traps without hardware source.
// - No DMA request from a source without resource number.
// - Serial status events never request DMA.
// - Reload timer channels 4 to 7 never request DMA.
// - Pulse channels 24 to 47 never request DMA.
// - 32-bit timer channels 3 to 5 never request DMA.
// - Clock calibration interrupt never requests DMA.
// - Low-voltage detection interrupt never requests DMA.
`timescale 1ns/1ps
`include "irq_map.svh"
module interrupt_vector_dma_request_map
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] vector_table_base,
  input wire logic ser3_tx_done,
  input wire logic ser4_rx_done,
  input wire logic ser4_status,
  input wire logic ser7_tx_done,
  input wire logic can1_irq,
  input wire logic [5:0] ram_diag_events,
  input wire logic frt0_event,
  input wire logic frt1_event,
  input wire logic [9:0] pulse_low_events,
  input wire logic [3:0] compare_events,
  input wire logic reload_hi_event,
  input wire logic pulse_hi_event,
  input wire logic frt32_hi_event,
  input wire logic clock_cal_event,
  input wire logic low_volt_event,
  input wire logic trap_valid,
  input wire logic [7:0] trap_vector,
  input wire logic irq_ack,
  output logic irq_valid,
  output logic [7:0] irq_vector,
  output logic [9:0] irq_offset,
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  output logic [5:0] dma_request,
  output logic dma_resource_number_valid,
  output logic [5:0] dma_resource_number
);
  // ==========================================================
  // Source table
  logic [`NUM_SRC-1:0] irq_src;
  logic [`NUM_SRC-1:0] dma_src;

  always_comb
  begin
    irq_src[irq_pkg::SRC_SER3_TX] = ser3_tx_done;
    irq_src[irq_pkg::SRC_SER4_RX] = ser4_rx_done | ser4_status;
    irq_src[irq_pkg::SRC_CAN1_RAM] = can1_irq | (|ram_diag_events);
    irq_src[irq_pkg::SRC_FRT0_SER7] = frt0_event | ser7_tx_done;
    irq_src[irq_pkg::SRC_PULSE_FRT1] = (|pulse_low_events) | frt1_event;
    irq_src[irq_pkg::SRC_COMPARE] = |compare_events;
    // Status never counts as a transfer trigger
    dma_src[irq_pkg::SRC_SER3_TX] = ser3_tx_done;
    dma_src[irq_pkg::SRC_SER4_RX] = ser4_rx_done;
    dma_src[irq_pkg::SRC_CAN1_RAM] = 1'b0;
    dma_src[irq_pkg::SRC_FRT0_SER7] = frt0_event | ser7_tx_done;
    dma_src[irq_pkg::SRC_PULSE_FRT1] = (|pulse_low_events) | frt1_event;
    dma_src[irq_pkg::SRC_COMPARE] = |compare_events;
  end

  // Reload 4-7, pulse 24-47, wide timers 3-5, calibration and low
  // voltage only reach vectors outside this map; they have no DMA path.
  logic no_dma_sources;
  assign no_dma_sources = reload_hi_event | pulse_hi_event | frt32_hi_event
    | clock_cal_event | low_volt_event;

  function automatic logic [7:0] src_vector(input logic [2:0] s);
    case (s)
      3'h0: src_vector = `VEC_SER3_TX;
      3'h1: src_vector = `VEC_SER4_RX;
      3'h2: src_vector = `VEC_CAN1_RAM;
      3'h3: src_vector = `VEC_FRT0_SER7;
      3'h4: src_vector = `VEC_PULSE_FRT1;
      default: src_vector = `VEC_COMPARE;
    endcase
  endfunction

  function automatic logic [5:0] src_res(input logic [2:0] s);
    case (s)
      3'h0: src_res = `RES_SER3_TX;
      3'h1: src_res = `RES_SER4_RX;
      3'h3: src_res = `RES_FRT0_SER7;
      3'h4: src_res = `RES_PULSE_FRT1;
      3'h5: src_res = `RES_COMPARE;
      default: src_res = 6'h00;
    endcase
  endfunction

  function automatic logic src_has_res(input logic [2:0] s);
    src_has_res = (s != 3'h2) && (s < 3'h6);
  endfunction

  function automatic logic [9:0] vec_offset(input logic [7:0] v);
    vec_offset = `OFS_TOP - {v, 2'b00};
  endfunction

  // ==========================================================
  // Vector arbitration, lowest vector first
  logic [2:0] win;
  logic any_hw;
  always_comb
  begin
    win = 3'h0;
    any_hw = 1'b0;
    for (int i = `NUM_SRC - 1; i >= 0; i--)
    begin
      if (irq_src[i])
      begin
        win = 3'(i);
        any_hw = 1'b1;
      end
    end
  end

  logic trap_ok;
  assign trap_ok = trap_valid && (trap_vector >= `VEC_SOFT_LO);

  irq_pkg::arb_state_t state_reg;
  irq_pkg::arb_state_t state_next;
  logic [7:0] vec_reg;
  logic [7:0] vec_next;
  logic [9:0] ofs_reg;
  logic [9:0] ofs_next;

  always_comb
  begin
    state_next = state_reg;
    vec_next = vec_reg;
    ofs_next = ofs_reg;
    case (state_reg)
      irq_pkg::ST_IDLE:
      begin
        // Hardware events win; a trap is taken only in a cycle with no hardware event, and is not held
        if (any_hw)
        begin
          vec_next = src_vector(win);
          ofs_next = vec_offset(src_vector(win));
          state_next = irq_pkg::ST_HOLD;
        end
        else if (trap_ok)
        begin
          vec_next = trap_vector;
          ofs_next = vec_offset(trap_vector);
          state_next = irq_pkg::ST_HOLD;
        end
      end
      irq_pkg::ST_HOLD:
      begin
        if (irq_ack)
        begin
          state_next = irq_pkg::ST_IDLE;
        end
      end
      default: state_next = irq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg <= irq_pkg::ST_IDLE;
      vec_reg <= 8'h00;
      ofs_reg <= 10'h000;
    end
    else
    begin
      state_reg <= state_next;
      vec_reg <= vec_next;
      ofs_reg <= ofs_next;
    end
  end

  assign irq_valid = (state_reg == irq_pkg::ST_HOLD);
  assign irq_vector = vec_reg;
  assign irq_offset = ofs_reg;

  vec_bus vb ();
  assign vb.valid = (state_reg == irq_pkg::ST_HOLD) && irq_ack;
  assign vb.vector = vec_reg;
  assign vb.offset = ofs_reg;

  vec_fetch u_fetch
  (
    .clk(clk),
    .rst_b(rst_b),
    .vector_table_base(vector_table_base),
    .vb(vb),
    .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr)
  );

  // ==========================================================
  // DMA requests, one cycle per event
  logic [5:0] dreq_reg;
  logic [5:0] dreq_next;
  logic rv_reg;
  logic rv_next;
  logic [5:0] rn_reg;
  logic [5:0] rn_next;

  always_comb
  begin
    dreq_next = 6'h00;
    rv_next = 1'b0;
    rn_next = rn_reg;
    for (int i = 0; i < `NUM_SRC; i++)
    begin
      if (dma_src[i] && src_has_res(3'(i)))
      begin
        dreq_next[i] = 1'b1;
      end
    end
    for (int i = `NUM_SRC - 1; i >= 0; i--)
    begin
      if (dreq_next[i])
      begin
        rv_next = 1'b1;
        rn_next = src_res(3'(i));
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dreq_reg <= 6'h00;
      rv_reg <= 1'b0;
      rn_reg <= 6'h00;
    end
    else
    begin
      dreq_reg <= dreq_next;
      rv_reg <= rv_next;
      rn_reg <= rn_next;
    end
  end

  // Unused here, but kept visible to show those events are excluded
  logic unused_ok;
  assign unused_ok = no_dma_sources;

  assign dma_request = dreq_reg;
  assign dma_resource_number_valid = rv_reg;
  assign dma_resource_number = rn_reg;
endmodule

// ==== rtl/irq_map.svh ====
// Vector, offset and resource-number constants for the interrupt map
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH
`define VEC_W 8
`define OFS_W 10
`define RES_W 6
`define OFS_TOP 10'h3fc
`define VEC_SER3_TX 8'h1b
`define OFS_SER3_TX 10'h390
`define RES_SER3_TX 6'h0b
`define VEC_SER4_RX 8'h1c
`define OFS_SER4_RX 10'h38c
`define RES_SER4_RX 6'h0c
`define VEC_CAN1_RAM 8'h23
`define OFS_CAN1_RAM 10'h370
`define VEC_FRT0_SER7 8'h27
`define OFS_FRT0_SER7 10'h360
`define RES_FRT0_SER7 6'h17
`define VEC_PULSE_FRT1 8'h28
`define OFS_PULSE_FRT1 10'h35c
`define RES_PULSE_FRT1 6'h18
`define VEC_COMPARE 8'h3a
`define OFS_COMPARE 10'h314
`define RES_COMPARE 6'h2a
`define VEC_SOFT_LO 8'h42
`define VEC_SOFT_HI 8'hff
`define NUM_SRC 6
`endif

// ==== rtl/irq_pkg.sv ====
// Types shared by the interrupt map modules
package irq_pkg;
  typedef enum logic [2:0] {
    SRC_SER3_TX,
    SRC_SER4_RX,
    SRC_CAN1_RAM,
    SRC_FRT0_SER7,
    SRC_PULSE_FRT1,
    SRC_COMPARE
  } src_t;
  typedef enum {ST_IDLE, ST_HOLD} arb_state_t;
endpackage

// ==== rtl/vec_bus.sv ====
// Interface carrying a chosen vector between map and fetch logic
`timescale 1ns/1ps
`include "irq_map.svh"
interface vec_bus;
  logic valid;
  logic [`VEC_W-1:0] vector;
  logic [`OFS_W-1:0] offset;
  modport src (output valid, output vector, output offset);
  modport dst (input valid, input vector, input offset);
endinterface

// ==== rtl/vec_fetch.sv ====
// Registered vector fetch address generator
`timescale 1ns/1ps
`include "irq_map.svh"
module vec_fetch
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] vector_table_base,
  vec_bus.dst vb,
  output logic fetch_valid,
  output logic [31:0] fetch_addr
);
  logic valid_reg;
  logic valid_next;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;

  always_comb
  begin
    valid_next = vb.valid;
    addr_next = addr_reg;
    if (vb.valid)
    begin
      addr_next = vector_table_base + {22'h0, vb.offset};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      valid_reg <= 1'b0;
      addr_reg <= 32'h00000000;
    end
    else
    begin
      valid_reg <= valid_next;
      addr_reg <= addr_next;
    end
  end

  assign fetch_valid = valid_reg;
  assign fetch_addr = addr_reg;
endmodule

// ==== sim/core_model.sv ====
// Processor core model that accepts presented vectors
`timescale 1ns/1ps
module core_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic irq_valid,
  input wire logic slow,
  output logic irq_ack
);
  // ==========
  // Acceptance
  logic [2:0] cnt_reg;
  // Slow mode lets the vector stand several cycles before acceptance
  always @(posedge clk)
  begin
    if (!rst_b || irq_valid !== 1'b1 || irq_ack)
    begin
      irq_ack <= 1'b0;
      cnt_reg <= 3'h0;
    end
    else if (cnt_reg >= (slow ? 3'h5 : 3'h0))
      irq_ack <= 1'b1;
    else
      cnt_reg <= cnt_reg + 3'h1;
  end
endmodule

// ==== sim/map_props.sv ====
// Port checker for the interrupt map
`timescale 1ns/1ps
module map_props
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] vector_table_base,
  input wire logic ser3_tx_done,
  input wire logic ser4_rx_done,
  input wire logic ser4_status,
  input wire logic can1_irq,
  input wire logic [3:0] compare_events,
  input wire logic irq_ack,
  input wire logic irq_valid,
  input wire logic [7:0] irq_vector,
  input wire logic [9:0] irq_offset,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic [5:0] dma_request,
  input wire logic [5:0] dma_resource_number
);
  // ==========
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_offset_calc: assert property (
    irq_valid |-> irq_offset == 10'h3fc - {irq_vector, 2'b00})
    else $error("offset not derived from vector");
  a_fetch_addr: assert property (
    irq_valid && irq_ack |=> fetch_valid
      && fetch_addr == $past(vector_table_base) + $past(irq_offset))
    else $error("fetch address wrong");
  a_ser3_vec: assert property (
    ser3_tx_done && !irq_valid |=> irq_valid && irq_vector == 8'h1b)
    else $error("serial 3 vector wrong");
  a_ser3_dma: assert property (
    ser3_tx_done |=> dma_request[0] && dma_resource_number == 6'h0b)
    else $error("serial 3 request wrong");
  a_status_nodma: assert property (
    ser4_status && !ser4_rx_done |=> !dma_request[1])
    else $error("status event requested transfer");
  a_ser4_rn: assert property (
    dma_request[1:0] == 2'b10 |-> dma_resource_number == 6'h0c)
    else $error("serial 4 resource wrong");
  a_can_nodma: assert property (
    can1_irq |=> !dma_request[2])
    else $error("shared diag vector requested transfer");
  a_cmp_dma: assert property (
    compare_events != 4'h0 |=> dma_request[5])
    else $error("compare request missing");
  a_cmp_rn: assert property (
    dma_request == 6'h20 |-> dma_resource_number == 6'h2a)
    else $error("compare resource wrong");
  a_soft_range: assert property (
    $rose(irq_valid) |-> irq_vector inside {8'h1b, 8'h1c, 8'h23,
      8'h27, 8'h28, 8'h3a} || irq_vector >= 8'h42)
    else $error("vector outside map");
endmodule
bind interrupt_vector_dma_request_map map_props i_map_props (.*);

// ==== sim/tb_top.sv ====
// Self-checking bench for the interrupt map
`timescale 1ns/1ps
module tb_top;
`define CHK(n,e,a) begin check_count++; if ((a) !== (e)) begin \
  failures++; $display("BAD %s exp %h got %h", n, e, a); end end
  // ==========
  // Signals
  logic clk = 0, rst_b = 0, trap_valid = 0, slow = 0, pv = 0;
  logic [31:0] base = '0, s = '0, rnd = 32'h86311afd;
  logic [7:0] trap_vector = '0, tv;
  logic irq_ack, irq_valid, fetch_valid, dma_resource_number_valid;
  logic [7:0] irq_vector;
  logic [9:0] irq_offset;
  logic [31:0] fetch_addr;
  logic [5:0] dma_request, dma_resource_number;
  logic [15:0] q[$], cur = '0;
  logic [9:0] eo = '0;
  int failures = 0, check_count = 0, k;
  always #5 clk = ~clk;
  interrupt_vector_dma_request_map i_interrupt_vector_dma_request_map (
    .clk(clk), .rst_b(rst_b), .vector_table_base(base),
    .ser3_tx_done(s[0]), .ser4_rx_done(s[1]), .ser4_status(s[2]),
    .ser7_tx_done(s[3]), .can1_irq(s[4]), .ram_diag_events(s[10:5]),
    .frt0_event(s[11]), .frt1_event(s[12]), .pulse_low_events(s[22:13]),
    .compare_events(s[26:23]), .reload_hi_event(s[27]),
    .pulse_hi_event(s[28]), .frt32_hi_event(s[29]),
    .clock_cal_event(s[30]), .low_volt_event(s[31]),
    .trap_valid(trap_valid), .trap_vector(trap_vector),
    .irq_ack(irq_ack), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_offset(irq_offset), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .dma_request(dma_request),
    .dma_resource_number_valid(dma_resource_number_valid),
    .dma_resource_number(dma_resource_number));
  core_model i_core_model (.clk(clk), .rst_b(rst_b),
    .irq_valid(irq_valid), .slow(slow), .irq_ack(irq_ack));
  // ==========
  // Expectations: irq, vector, dma flag, resource number
  function automatic logic [15:0] expect_of(input int k);
    if (k == 0) return {1'b1, 8'h1b, 7'h4b};
    if (k < 3) return {1'b1, 8'h1c, k == 1, 6'h0c};
    if (k == 3 || k == 11) return {1'b1, 8'h27, 7'h57};
    if (k < 11) return {1'b1, 8'h23, 7'h00};
    if (k < 23) return {1'b1, 8'h28, 7'h58};
    if (k < 27) return {1'b1, 8'h3a, 7'h6a};
    return '0;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic go(input logic [31:0] v, input logic [8:0] t,
    input logic [15:0] e);
    int i;
    rnd = lfsr(rnd);
    @(posedge clk);
    if (e[15]) q.push_back(e);
    s <= v;
    {trap_valid, trap_vector} <= t;
    base <= rnd;
    slow <= rnd[3];
    @(posedge clk);
    s <= '0;
    trap_valid <= 1'b0;
    for (i = 0; i < 3 || (irq_valid !== 1'b0 && i < 40); i++)
      @(posedge clk);
  endtask
  task test_done;
    if (failures == 0 && check_count > 0 && q.size() == 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // Monitor
  // Outputs hold unknowns until the first reset edge, so skip them
  always @(posedge clk)
  begin
    if (rst_b === 1'b1)
    begin
      if (irq_valid === 1'b1 && pv !== 1'b1)
      begin
        cur = q.size() ? q.pop_front() : 16'h0;
        eo = 10'h3fc - {cur[14:7], 2'b00};
        `CHK("vector", cur[14:7], irq_vector)
        `CHK("offset", eo, irq_offset)
        `CHK("dma_valid", cur[6], dma_resource_number_valid)
        `CHK("dma_any", cur[6], |dma_request)
        if (cur[6]) `CHK("rn", cur[5:0], dma_resource_number)
      end
      else
      begin
        `CHK("dma_idle", 1'b0, dma_resource_number_valid)
        `CHK("req_idle", 6'h00, dma_request)
      end
      if (fetch_valid === 1'b1)
        `CHK("fetch", base + 32'(eo), fetch_addr)
    end
    pv <= irq_valid;
  end
  // ==========
  // Stimulus
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (k = 0; k < 32; k++)
      go(32'h1 << k, 9'h0, expect_of(k));
    // Lowest vector wins; the dropped compare event is not kept
    go(32'h00800001, 9'h0, {1'b1, 8'h1b, 7'h4b});
    // Hardware beats a trap raised in the same cycle
    go(32'h00000001, {1'b1, 8'h50}, {1'b1, 8'h1b, 7'h4b});
    for (k = 0; k < 8; k++)
    begin
      tv = (k < 2) ? 8'h41 + 8'(k) : rnd[7:0];
      go('0, {1'b1, tv}, tv >= 8'h42 ? {1'b1, tv, 7'h0} : 16'h0);
    end
    test_done;
  end
  // Whole run is under 400 cycles
  initial
  begin
    #100000;
    failures++;
    test_done;
  end
endmodule
